// ---- rtl/expander_cfg.svh ----
// Purpose: Offsets, field positions, reset values and framing constants
// Assumes: Included by the expander design files only
// Notes: Definitions only, guarded against double inclusion
`ifndef EXPANDER_CFG_SVH
`define EXPANDER_CFG_SVH

// ****************************************
// Register offsets, paired map
// ****************************************
`define CMP_SEL_A_PAIRED 8'h08
`define CMP_SEL_B_PAIRED 8'h09
`define CONFIG_A_PAIRED 8'h0a
`define CONFIG_B_PAIRED 8'h0b

// ****************************************
// Register offsets, split map
// ****************************************
`define CMP_SEL_A_SPLIT 8'h04
`define CMP_SEL_B_SPLIT 8'h14
`define CONFIG_A_SPLIT 8'h05
`define CONFIG_B_SPLIT 8'h15

// ****************************************
// Configuration field positions
// ****************************************
`define CFG_MAP_SPLIT 7
`define CFG_IRQ_JOIN 6
`define CFG_AUTOINC_DIS 5
`define CFG_SLEW_OFF 4
`define CFG_ADDR_PIN_EN 3
`define CFG_OPEN_DRAIN 2
`define CFG_ACTIVE_LEVEL 1

// ****************************************
// Reset values and masks
// ****************************************
`define CMP_SEL_RESET 8'h00
`define CONFIG_RESET 8'h00
`define CONFIG_WMASK 8'hfe
`define PTR_RESET 8'h00

// ****************************************
// Serial framing
// ****************************************
`define OPCODE_FIXED 4'h4
`define LAST_BIT 3'h7

`endif

// ---- rtl/expander_pkg.sv ----
// Purpose: Types shared by the expander design files
// Assumes: Nothing beyond the language
// Notes: Numbers live in expander_cfg.svh
package expander_pkg;
  // Serial transfer phase
  typedef enum logic [1:0] {
    ST_OPCODE,
    ST_ADDR,
    ST_DATA,
    ST_IGNORE
  } xfer_state_t;

  // Register picked by an address
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_CMP_A,
    SEL_CMP_B,
    SEL_CONFIG
  } reg_sel_t;
endpackage

// ---- rtl/irq_port_if.sv ----
// Purpose: Carries one port's change-detect inputs and result
// Assumes: All signals on mclk
// Notes: ctrl side is the register bank, eval side the detector
`timescale 1ns/100ps
interface irq_port_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] pins; // Synchronised pin levels
  logic [WIDTH-1:0] default_val; // Default compare value
  logic [WIDTH-1:0] enable; // Per-pin change enable
  logic [WIDTH-1:0] cmp_sel; // 1 = compare to default
  logic clear; // Pulse, clears pending flags
  logic pending; // Any flag pending
  modport ctrl (output pins, output default_val, output enable,
    output cmp_sel, output clear, input pending);
  modport eval (input pins, input default_val, input enable,
    input cmp_sel, input clear, output pending);
endinterface

// ---- rtl/irq_change_eval.sv ----
// Purpose: Interrupt-on-change detection for one port
// Assumes: Pins already synchronised to mclk
// Notes: Flags are sticky until clear; a new event beats the clear
`timescale 1ns/100ps
module irq_change_eval import expander_pkg::*; #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  irq_port_if.eval port
);

  logic [WIDTH-1:0] prev_reg; // Pin levels seen last cycle
  logic primed_reg; // prev_reg holds a real sample
  logic [WIDTH-1:0] flag_reg; // Sticky per-pin flags
  logic [WIDTH-1:0] cond; // Raw change condition
  logic [WIDTH-1:0] flag_next;

  // Default compare, or change against the previous level
  assign cond = port.enable & ((port.cmp_sel & (port.pins ^
    port.default_val)) | (~port.cmp_sel & (port.pins ^ prev_reg) &
    {WIDTH{primed_reg}})); // R1 R2 R18 R19
  // Set wins over clear so no event is lost
  assign flag_next = cond | (flag_reg & ~{WIDTH{port.clear}});
  assign port.pending = |flag_reg; // R20

  // Sample history and flags
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prev_reg <= '0;
      primed_reg <= 1'b0;
      flag_reg <= '0;
    end else if (ce) begin
      prev_reg <= port.pins;
      primed_reg <= 1'b1;
      flag_reg <= flag_next;
    end
  end

  AST_DEFAULT_VALUE_REGISTER_CMP: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && |(port.enable & port.cmp_sel & (port.pins ^ port.default_val))
    |=> port.pending) else $error("default mismatch not flagged"); // R1
  AST_PREV_CMP: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && primed_reg && |(port.enable & ~port.cmp_sel &
    (port.pins ^ prev_reg)) |=> port.pending)
    else $error("pin change not flagged"); // R2
  AST_DISABLED_PIN: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && port.enable == '0 |=> flag_reg == ($past(flag_reg) &
    ~{WIDTH{$past(port.clear)}})) else $error("disabled pin set flag"); // R19
endmodule

// ---- rtl/expander_regs.sv ----
// Purpose: Compare-select and configuration registers of the expander
// Assumes: Serial link slower than mclk by a factor of eight or more
// Notes: Other expander registers live outside; their offsets read 0
`timescale 1ns/100ps
`include "expander_cfg.svh"

// Function
// [R1] Select one compares pin with default
// [R2] Select zero flags change from previous
// [R3] Split map: A at 00-0A, B 10-1A
// [R4] Paired map interleaves A and B
// [R5] New map applies from next byte
// [R6] Auto-increment after 0Ah write gives 0Bh
// [R7] Host changes map with single-byte writes
// [R8] Join: either port drives both outputs
// [R9] Separate: each output follows own port
// [R10] Auto-increment off keeps pointer fixed
// [R11] Slew setting limits falling data edges
// [R12] Address pins enabled: match pin levels
// [R13] Address pins disabled: address is zero
// [R14] Board biases address pins always
// [R15] Open drain overrides polarity
// [R16] Polarity sets push-pull active level
// [R17] Reset to zero; bit zero reads zero
// [R18] Default mode flags opposite pin level
// [R19] Only enabled pins are evaluated
// [R20] Output holds while any flag pending
module expander_regs import expander_pkg::*; (
  input wire logic mclk, // System clock, 100 MHz
  input wire logic arst_n, // Asynchronous reset, low active
  input wire logic ce, // Clock enable, freezes all state
  input wire logic link_sck, // Serial clock from host
  input wire logic link_cs_n, // Chip select, low active
  input wire logic link_sdi, // Serial data in
  output logic link_sdo, // Serial data out
  output logic link_sdo_oe_n, // Low while driving link_sdo
  input wire logic addr_pin_2, // Hardware address pins
  input wire logic addr_pin_1,
  input wire logic addr_pin_0,
  input wire logic [7:0] port_a_a, // Port A pin levels
  input wire logic [7:0] port_b_b, // Port B pin levels
  input wire logic [7:0] default_value_a, // Default compare, port A
  input wire logic [7:0] default_value_b, // Default compare, port B
  input wire logic [7:0] change_irq_enable_a, // Per-pin enable, A
  input wire logic [7:0] change_irq_enable_b, // Per-pin enable, B
  input wire logic irq_clear_a, // Pulse, clears A flags
  input wire logic irq_clear_b, // Pulse, clears B flags
  output logic irq_out_a, // Interrupt pin A level
  output logic irq_out_a_oe_n, // Low while driving pin A
  output logic irq_out_b, // Interrupt pin B level
  output logic irq_out_b_oe_n, // Low while driving pin B
  output logic data_line_slew_limit, // High: limit falling slew
  output logic [2:0] hw_address // Address in force
);
  // Sequencer and decode types come from the package

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [5:0] link_m_reg; // First stage, read by link_s_reg only
  logic [5:0] link_s_reg; // Second stage
  logic sck_d_reg; // Delayed clock for edge finding
  logic [15:0] pins_m_reg; // First stage of port pins
  logic [15:0] pins_s_reg; // Second stage of port pins

  // Two flops on every pin from outside the mclk domain
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      link_m_reg <= 6'h10; // Idle link: deselected, sck low
      link_s_reg <= 6'h10;
      sck_d_reg <= 1'b0;
      pins_m_reg <= 16'h0000;
      pins_s_reg <= 16'h0000;
    end else if (ce) begin
      link_m_reg <= {link_sck, link_cs_n, link_sdi, addr_pin_2,
        addr_pin_1, addr_pin_0};
      link_s_reg <= link_m_reg;
      sck_d_reg <= link_s_reg[5];
      pins_m_reg <= {port_b_b, port_a_a};
      pins_s_reg <= pins_m_reg;
    end
  end

  // Named views of the synchronised link
  logic sck_s;
  logic cs_n_s;
  logic sdi_s;
  logic [2:0] addr_pins_s;
  logic sck_rise;
  logic sck_fall;
  assign sck_s = link_s_reg[5];
  assign cs_n_s = link_s_reg[4];
  assign sdi_s = link_s_reg[3];
  assign addr_pins_s = link_s_reg[2:0];
  assign sck_rise = ce && !cs_n_s && sck_s && !sck_d_reg;
  assign sck_fall = ce && !cs_n_s && !sck_s && sck_d_reg;

  // ****************************************
  // Registers and decode
  // ****************************************
  logic [7:0] cmp_a_reg; // Compare select, port A
  logic [7:0] cmp_b_reg; // Compare select, port B
  logic [7:0] cfg_reg; // Configuration, bit 0 held at zero
  logic [7:0] ptr_reg; // Register address pointer

  // Address to register, per map layout
  function automatic reg_sel_t decode_addr(input logic [7:0] a,
    input logic split);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (split) begin // R3
      case (a)
        `CMP_SEL_A_SPLIT: sel = SEL_CMP_A;
        `CMP_SEL_B_SPLIT: sel = SEL_CMP_B;
        `CONFIG_A_SPLIT, `CONFIG_B_SPLIT: sel = SEL_CONFIG;
        default: sel = SEL_NONE;
      endcase
    end else begin // R4
      case (a)
        `CMP_SEL_A_PAIRED: sel = SEL_CMP_A;
        `CMP_SEL_B_PAIRED: sel = SEL_CMP_B;
        `CONFIG_A_PAIRED, `CONFIG_B_PAIRED: sel = SEL_CONFIG;
        default: sel = SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  // Read value of a register; unknown offsets read zero
  function automatic logic [7:0] read_value(input reg_sel_t sel,
    input logic [7:0] ca, input logic [7:0] cb, input logic [7:0] cf);
    logic [7:0] v;
    v = 8'h00;
    case (sel)
      SEL_CMP_A: v = ca;
      SEL_CMP_B: v = cb;
      SEL_CONFIG: v = cf & `CONFIG_WMASK; // R17
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // Configuration fields
  logic map_split;
  logic irq_join;
  logic autoinc_dis;
  logic open_drain;
  logic active_level;
  assign map_split = cfg_reg[`CFG_MAP_SPLIT];
  assign irq_join = cfg_reg[`CFG_IRQ_JOIN];
  assign autoinc_dis = cfg_reg[`CFG_AUTOINC_DIS];
  assign open_drain = cfg_reg[`CFG_OPEN_DRAIN];
  assign active_level = cfg_reg[`CFG_ACTIVE_LEVEL];

  // Address pins count only when enabled
  assign hw_address = cfg_reg[`CFG_ADDR_PIN_EN] ? addr_pins_s :
    3'h0; // R12 R13
  assign data_line_slew_limit = !cfg_reg[`CFG_SLEW_OFF]; // R11

  // ****************************************
  // Serial transfer sequencer
  // ****************************************
  xfer_state_t state_reg;
  xfer_state_t state_next;
  logic [2:0] bit_cnt_reg; // Bits taken in this byte
  logic [7:0] rx_reg; // Shift in
  logic [7:0] tx_reg; // Shift out, MSB on the line
  logic rd_mode_reg; // Transfer is a read
  logic [7:0] rx_byte; // Byte including the bit now sampled
  logic byte_done; // Eighth bit sampled
  logic opcode_ok; // Opcode and address match
  logic wr_en; // Data byte written
  reg_sel_t ptr_sel; // Register under the pointer
  logic [7:0] ptr_next;
  logic [7:0] ptr_step; // Pointer after a data byte

  assign rx_byte = {rx_reg[6:0], sdi_s};
  assign byte_done = sck_rise && bit_cnt_reg == `LAST_BIT;
  assign opcode_ok = rx_byte[7:4] == `OPCODE_FIXED &&
    rx_byte[3:1] == hw_address; // R12 R13
  assign ptr_sel = decode_addr(ptr_reg, map_split); // R5
  assign wr_en = byte_done && state_reg == ST_DATA && !rd_mode_reg;
  // Fixed pointer allows polling one register
  assign ptr_step = autoinc_dis ? ptr_reg : ptr_reg + 8'h01; // R10 R6
  assign ptr_next = (byte_done && state_reg == ST_ADDR) ? rx_byte :
    (byte_done && state_reg == ST_DATA) ? ptr_step : ptr_reg;
  assign link_sdo = tx_reg[7];
  assign link_sdo_oe_n = !(!cs_n_s && state_reg == ST_DATA &&
    rd_mode_reg);

  // Phase of the transfer, advanced at each whole byte
  always_comb begin
    state_next = state_reg;
    if (cs_n_s) begin
      state_next = ST_OPCODE;
    end else if (byte_done) begin
      case (state_reg)
        ST_OPCODE: state_next = opcode_ok ? ST_ADDR : ST_IGNORE;
        ST_ADDR: state_next = ST_DATA;
        ST_DATA: state_next = ST_DATA;
        ST_IGNORE: state_next = ST_IGNORE;
        default: state_next = ST_OPCODE;
      endcase
    end
  end

  // Shift in and count bits; deselect restarts framing
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_OPCODE;
      bit_cnt_reg <= 3'h0;
      rx_reg <= 8'h00;
    end else if (ce) begin
      state_reg <= state_next;
      if (cs_n_s) begin
        bit_cnt_reg <= 3'h0;
      end else if (sck_rise) begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        rx_reg <= rx_byte;
      end
    end
  end

  // Pointer and read/write direction
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_reg <= `PTR_RESET;
      rd_mode_reg <= 1'b0;
    end else if (ce) begin
      ptr_reg <= ptr_next;
      if (byte_done && state_reg == ST_OPCODE) begin
        rd_mode_reg <= rx_byte[0];
      end
    end
  end

  // Read data: reload at each byte boundary, else shift on falling sck, except the first fall after a reload.
  // The reload uses the pointer that the coming byte will address.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_reg <= 8'h00;
    end else if (ce) begin
      if (byte_done) begin
        tx_reg <= read_value(decode_addr(ptr_next, map_split),
          cmp_a_reg, cmp_b_reg, cfg_reg);
      end else if (sck_fall && bit_cnt_reg != 3'h0) begin
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  // Register writes; the map takes effect from the next byte
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmp_a_reg <= `CMP_SEL_RESET; // R17
      cmp_b_reg <= `CMP_SEL_RESET;
      cfg_reg <= `CONFIG_RESET;
    end else if (ce && wr_en) begin
      case (ptr_sel)
        SEL_CMP_A: cmp_a_reg <= rx_byte;
        SEL_CMP_B: cmp_b_reg <= rx_byte;
        SEL_CONFIG: cfg_reg <= rx_byte & `CONFIG_WMASK; // R17 R5
        default: cmp_a_reg <= cmp_a_reg;
      endcase
    end
  end

  // ****************************************
  // Change detection and interrupt pins
  // ****************************************
  irq_port_if #(.WIDTH(8)) if_a ();
  irq_port_if #(.WIDTH(8)) if_b ();

  assign if_a.pins = pins_s_reg[7:0];
  assign if_a.default_val = default_value_a;
  assign if_a.enable = change_irq_enable_a;
  assign if_a.cmp_sel = cmp_a_reg; // R1 R2
  assign if_a.clear = irq_clear_a;
  assign if_b.pins = pins_s_reg[15:8];
  assign if_b.default_val = default_value_b;
  assign if_b.enable = change_irq_enable_b;
  assign if_b.cmp_sel = cmp_b_reg;
  assign if_b.clear = irq_clear_b;

  irq_change_eval #(.WIDTH(8)) eval_a (.mclk(mclk), .arst_n(arst_n),
    .ce(ce), .port(if_a.eval));
  irq_change_eval #(.WIDTH(8)) eval_b (.mclk(mclk), .arst_n(arst_n),
    .ce(ce), .port(if_b.eval));

  // Joined pins see both ports, separate pins their own
  logic act_a;
  logic act_b;
  logic act_a_reg; // Pin A asserted
  logic act_b_reg; // Pin B asserted
  assign act_a = irq_join ? (if_a.pending || if_b.pending) :
    if_a.pending; // R8 R9 R20
  assign act_b = irq_join ? (if_a.pending || if_b.pending) :
    if_b.pending; // R8 R9 R20

  // Open drain pulls low or floats; push-pull drives the chosen level
  function automatic logic [1:0] pin_drive(input logic act,
    input logic od, input logic lvl);
    logic [1:0] d; // {level, oe_n}
    d = 2'h0;
    if (od) begin
      d = {1'b0, !act}; // R15
    end else begin
      d = {act ? lvl : !lvl, 1'b0}; // R16
    end
    return d;
  endfunction

  logic [1:0] drv_a_next;
  logic [1:0] drv_b_next;
  assign drv_a_next = pin_drive(act_a_reg, open_drain, active_level);
  assign drv_b_next = pin_drive(act_b_reg, open_drain, active_level);

  // Registered pin drive; reset leaves pins floating
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      act_a_reg <= 1'b0;
      act_b_reg <= 1'b0;
      {irq_out_a, irq_out_a_oe_n} <= 2'h1;
      {irq_out_b, irq_out_b_oe_n} <= 2'h1;
    end else if (ce) begin
      act_a_reg <= act_a;
      act_b_reg <= act_b;
      {irq_out_a, irq_out_a_oe_n} <= drv_a_next;
      {irq_out_b, irq_out_b_oe_n} <= drv_b_next;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence wr_split_on;
    ce && wr_en && ptr_sel == SEL_CONFIG && rx_byte[`CFG_MAP_SPLIT];
  endsequence
  sequence paired_cfg_write_80;
    ce && wr_en && !map_split && !autoinc_dis &&
      ptr_reg == `CONFIG_A_PAIRED && rx_byte == 8'h80;
  endsequence

  AST_MAP_SWITCH: assert property (@(posedge mclk) disable iff (!arst_n)
    wr_split_on |=> map_split && ptr_sel == decode_addr(ptr_reg, 1'b1))
    else $error("map did not switch after byte"); // R5
  AST_PTR_INVALID: assert property (@(posedge mclk) disable iff (!arst_n)
    paired_cfg_write_80 |=> ptr_reg == `CONFIG_B_PAIRED &&
    ptr_sel == SEL_NONE) else $error("pointer not at invalid 0Bh"); // R6
  AST_PTR_HOLD: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && byte_done && state_reg == ST_DATA && autoinc_dis |=>
    $stable(ptr_reg)) else $error("pointer moved with autoinc off"); // R10
  AST_JOIN: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && irq_join && if_b.pending |=> act_a_reg && act_b_reg)
    else $error("joined pin missed other port"); // R8
  AST_SEPARATE: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && !irq_join && !if_a.pending && if_b.pending |=> !act_a_reg)
    else $error("pin A followed port B"); // R9
  AST_OPEN_DRAIN: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && open_drain |=> !irq_out_a && irq_out_a_oe_n == !$past(act_a_reg))
    else $error("open drain drive wrong"); // R15
  AST_POLARITY: assert property (@(posedge mclk) disable iff (!arst_n)
    ce && !open_drain && act_b_reg |=> !irq_out_b_oe_n &&
    irq_out_b == $past(active_level)) else $error("push-pull level"); // R16
  AST_ADDR_ZERO: assert property (@(posedge mclk) disable iff (!arst_n)
    !cfg_reg[`CFG_ADDR_PIN_EN] |-> hw_address == 3'h0)
    else $error("address pins used while disabled"); // R13
  AST_BIT0_ZERO: assert property (@(posedge mclk) disable iff (!arst_n)
    cfg_reg[0] == 1'b0) else $error("config bit 0 set"); // R17
endmodule

// ---- sim/spi_host_model.sv ----
// Purpose: Serial host model for the expander link
// Assumes: Mode 0 framing with an sck period of 125 ns
// Notes: sck stands low between frames; released sdi shows its inverse
`timescale 1ns/100ps
module spi_host_model (
  input wire logic link_sdo,
  input wire logic link_sdo_oe_n,
  output logic link_sck,
  output logic link_cs_n,
  output logic link_sdi
);
  // ****************************************
  // Idle link
  // ****************************************
  // Deselected, clock parked low
  initial begin
    link_sck = 1'b0;
    link_cs_n = 1'b1;
    link_sdi = 1'b0;
  end

  // ****************************************
  // Byte and frame tasks
  // ****************************************
  // One byte MSB first; sdi moves while sck is low, sdo taken at rise
  task shift(input logic [7:0] tx, output logic [7:0] rx, inout int lows);
    for (int i = 7; i >= 0; i--) begin
      link_sdi = tx[i];
      #62.5 link_sck = 1'b1;
      // A released line shows the inverse, so a missing drive is caught
      rx[i] = (link_sdo_oe_n === 1'b0) ? link_sdo : ~link_sdo;
      // Count rises at which the device drives sdo
      if (link_sdo_oe_n === 1'b0) begin
        lows++;
      end
      #62.5 link_sck = 1'b0;
    end
  endtask

  // Opcode, address, then n data bytes; lows counts driven sdo bits
  task frame(input logic [7:0] op, input logic [7:0] addr,
    input logic [7:0] d0, input logic [7:0] d1, input int n,
    output logic [7:0] r0, output logic [7:0] r1, output logic [7:0] lows);
    logic [7:0] junk;
    int cnt;
    cnt = 0;
    r0 = 8'h00;
    r1 = 8'h00;
    // Start off the mclk edge so no pin moves as it is sampled
    #1 link_cs_n = 1'b0;
    #40;
    shift(op, junk, cnt);
    shift(addr, junk, cnt);
    if (n > 0) begin
      shift(d0, r0, cnt);
    end
    if (n > 1) begin
      shift(d1, r1, cnt);
    end
    // Released line must not keep its last value
    link_sdi = ~link_sdi;
    #40 link_cs_n = 1'b1;
    // Gap lets the last byte land before the next frame
    #99;
    lows = 8'(cnt);
  endtask
endmodule

// ---- sim/expander_regs_tb_top.sv ----
// Purpose: Self-checking bench for the expander register bank
// Assumes: Host model drives the link; pins change on mclk rise
// Notes: Expected values are worked out here from the register rules
`timescale 1ns/100ps
module expander_regs_tb_top;
  logic mclk, arst_n, ce, sck, cs_n, sdi, sdo, sdo_oe_n;
  logic [2:0] apins; // Address pins, always biased
  logic [7:0] pa, pb, dva, dvb, ena, enb;
  logic clra, clrb, ia, ia_oe_n, ib, ib_oe_n, slew;
  logic [2:0] hw;
  logic [7:0] devop, cfg, r0, r1, lows; // Opcode and config in force
  int fail_count, num_checks;

  expander_regs expander_regs_inst (.mclk(mclk), .arst_n(arst_n),
    .ce(ce), .link_sck(sck), .link_cs_n(cs_n), .link_sdi(sdi),
    .link_sdo(sdo), .link_sdo_oe_n(sdo_oe_n), .addr_pin_2(apins[2]),
    .addr_pin_1(apins[1]), .addr_pin_0(apins[0]), .port_a_a(pa),
    .port_b_b(pb), .default_value_a(dva), .default_value_b(dvb),
    .change_irq_enable_a(ena), .change_irq_enable_b(enb),
    .irq_clear_a(clra), .irq_clear_b(clrb), .irq_out_a(ia),
    .irq_out_a_oe_n(ia_oe_n), .irq_out_b(ib), .irq_out_b_oe_n(ib_oe_n),
    .data_line_slew_limit(slew), .hw_address(hw));
  spi_host_model spi_host_model_inst (.link_sdo(sdo),
    .link_sdo_oe_n(sdo_oe_n), .link_sck(sck), .link_cs_n(cs_n),
    .link_sdi(sdi));

  // ****************************************
  // Clock, watchdog, report
  // ****************************************
  // 100 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // A hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge mclk);
    fail_count++;
    final_report;
  end
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // Helpers
  // ****************************************
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task wr(input logic [7:0] a, d0, d1, input int n);
    spi_host_model_inst.frame(devop, a, d0, d1, n, r0, r1, lows);
    chk("write drive count", 8'h00, lows);
  endtask
  // Two-byte read; sdo driven for all 16 data bits only
  task rd(input logic [7:0] a, e0, e1);
    spi_host_model_inst.frame(devop | 8'h01, a, 8'h00, 8'h00, 2, r0, r1,
      lows);
    chk("read drive count", 8'h10, lows);
    chk("read byte 0", e0, r0);
    chk("read byte 1", e1, r1);
  endtask
  task setcfg(input logic [7:0] v);
    wr(8'h0a, v, 8'h00, 1);
    cfg = v & 8'hfe;
  endtask
  // Pin level and enable for an active or idle output
  function logic [1:0] pexp(input logic act);
    if (cfg[2]) begin
      return {1'b0, ~act};
    end
    return {~(act ^ cfg[1]), 1'b0};
  endfunction
  task irq_chk(input logic aa, input logic ab);
    repeat (8) @(posedge mclk);
    #1;
    chk("irq pins", {4'h0, pexp(aa), pexp(ab)},
      {4'h0, ia, ia_oe_n, ib, ib_oe_n});
    // Back on the edge so the next stimulus lands on a rise
    @(posedge mclk);
  endtask
  // Settle synchronisers first, then a one-cycle clear
  task pulse(input logic b);
    repeat (6) @(posedge mclk);
    clra <= ~b;
    clrb <= b;
    @(posedge mclk);
    clra <= 1'b0;
    clrb <= 1'b0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    chk("slew limit", 8'h01, {7'h0, slew});
    chk("hw address", 8'h00, {5'h0, hw});
    chk("irq a oe_n", 8'h01, {7'h0, ia_oe_n});
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(8'h08, 8'h00, 8'h00);
    rd(8'h0a, 8'h00, 8'h00);
  endtask
  task t_paired;
    wr(8'h08, 8'h0f, 8'ha4, 2);
    rd(8'h08, 8'h0f, 8'ha4);
    setcfg(8'h21);
    rd(8'h0a, 8'h20, 8'h20);
    wr(8'h08, 8'h11, 8'h0f, 2);
    setcfg(8'h00);
    rd(8'h08, 8'h0f, 8'ha4);
  endtask
  task t_addr;
    setcfg(8'h08);
    chk("hw address", 8'h05, {5'h0, hw});
    spi_host_model_inst.frame(8'h41, 8'h0a, 8'h00, 8'h00, 2, r0, r1, lows);
    chk("refused drive count", 8'h00, lows);
    devop = 8'h4a;
    rd(8'h0a, 8'h08, 8'h08);
    setcfg(8'h00);
    devop = 8'h40;
    chk("hw address", 8'h00, {5'h0, hw});
    setcfg(8'h10);
    chk("slew limit", 8'h00, {7'h0, slew});
    setcfg(8'h00);
    chk("slew limit", 8'h01, {7'h0, slew});
  endtask
  // Second byte lands on 0Bh, which the split map leaves unmapped
  task t_split;
    wr(8'h0a, 8'h80, 8'h33, 2);
    rd(8'h05, 8'h80, 8'h00);
    rd(8'h04, 8'h0f, 8'h80);
    rd(8'h14, 8'ha4, 8'h80);
    rd(8'h08, 8'h00, 8'h00);
    wr(8'h05, 8'h00, 8'h00, 1);
    rd(8'h0a, 8'h00, 8'h00);
  endtask
  task t_irq;
    ena <= 8'h11;
    enb <= 8'h01;
    irq_chk(1'b0, 1'b0);
    pa[4] <= 1'b1;
    irq_chk(1'b1, 1'b0);
    repeat (20) @(posedge mclk);
    irq_chk(1'b1, 1'b0);
    pulse(1'b0);
    irq_chk(1'b0, 1'b0);
    pa[5] <= 1'b1;
    irq_chk(1'b0, 1'b0);
    pa[0] <= 1'b1;
    irq_chk(1'b1, 1'b0);
    pulse(1'b0);
    irq_chk(1'b1, 1'b0);
    pa[0] <= 1'b0;
    pulse(1'b0);
    irq_chk(1'b0, 1'b0);
    dva[0] <= 1'b1;
    irq_chk(1'b1, 1'b0);
    dva[0] <= 1'b0;
    pulse(1'b0);
    setcfg(8'h40);
    pb[0] <= 1'b1;
    irq_chk(1'b1, 1'b1);
    setcfg(8'h42);
    irq_chk(1'b1, 1'b1);
    setcfg(8'h46);
    irq_chk(1'b1, 1'b1);
    pulse(1'b1);
    irq_chk(1'b0, 1'b0);
    setcfg(8'h02);
    irq_chk(1'b0, 1'b0);
    pb[0] <= 1'b0;
    irq_chk(1'b0, 1'b1);
  endtask

  // Main sequence; inputs valued at time zero, then moved on mclk rise
  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    apins = 3'b101;
    {pa, pb, dva, dvb, ena, enb} = '0;
    {clra, clrb} = 2'b00;
    devop = 8'h40;
    cfg = 8'h00;
    fail_count = 0;
    num_checks = 0;
    repeat (10) @(posedge mclk);
    t_reset;
    t_paired;
    t_addr;
    t_split;
    t_irq;
    final_report;
  end
endmodule
